// ---- src/vcs_consts.svh ----
`ifndef VCS_CONSTS_SVH
`define VCS_CONSTS_SVH

`define VCS_ADDR_TRIM       8'h59
`define VCS_ADDR_HOLD       8'h5c
`define VCS_ADDR_CTRL       8'h5d
`define VCS_ADDR_STATE      8'h5e

`define VCS_HOLD_BIT        0
`define VCS_EN_BIT          0
`define VCS_STL_MSB         6
`define VCS_STL_LSB         4
`define VCS_TRIM_MSB        6

`define VCS_HOLD_RST        1'h0
`define VCS_EN_RST          1'h0
`define VCS_STL_RST         3'h4
`define VCS_TRIM_RST        7'h00
`define VCS_TRIM_MID        7'h40
`define VCS_TOP_IDX         3'h6

`define VCS_CLK_NS          40
`define VCS_SETTLE_UNIT_NS  1000
`define VCS_SETTLE_UNIT_CYC ((`VCS_SETTLE_UNIT_NS + `VCS_CLK_NS - 1) / `VCS_CLK_NS)

`endif

// ---- src/vcs_pkg.sv ----
package vcs_pkg;

  typedef enum logic [1:0] {
    VCS_IDLE,
    VCS_SETTLE,
    VCS_DONE
  } vcs_state_t;

  typedef struct packed {
    logic       hold;
    logic       en;
    logic [2:0] settle;
    logic [6:0] trim;
    logic       done;
    vcs_state_t state;
    logic [2:0] idx;
    logic [7:0] cnt;
    logic [7:0] rdata;
  } vcs_regs_t;

endpackage : vcs_pkg

// ---- src/vcs_sequencer.sv ----
`timescale 1ns/1ps
`include "vcs_consts.svh"

module vcs_sequencer #(
  parameter int unsigned SETTLE_UNIT_CYC = `VCS_SETTLE_UNIT_CYC
) (
  input  wire logic       clk_sys_in,
  input  wire logic       nrst_in,
  input  wire logic [7:0] addr_in,
  input  wire logic       wr_en_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       rd_en_in,
  output logic      [7:0] rd_data_out,
  input  wire logic       osc_fast_in,
  output logic      [6:0] osc_tuning_word_out,
  output logic            synth_hold_reset_out,
  output logic            osc_cal_finished_out
);

  vcs_pkg::vcs_regs_t r_r;
  vcs_pkg::vcs_regs_t r_nxt;

  logic       release_w;
  logic [7:0] settle_cnt;

  // Settle span scales with the code; code 0 still waits one unit
  assign settle_cnt = 8'(({5'h0, r_r.settle} + 8'h01) * SETTLE_UNIT_CYC);
  assign release_w  = wr_en_in && addr_in == `VCS_ADDR_HOLD && r_r.hold
                      && !wr_data_in[`VCS_HOLD_BIT];

  always_comb begin
    r_nxt = r_r;
    if (wr_en_in) begin
      unique case (addr_in)
        `VCS_ADDR_HOLD: r_nxt.hold = wr_data_in[`VCS_HOLD_BIT];
        `VCS_ADDR_CTRL: begin
          r_nxt.en     = wr_data_in[`VCS_EN_BIT];
          r_nxt.settle = wr_data_in[`VCS_STL_MSB:`VCS_STL_LSB];
        end
        `VCS_ADDR_TRIM: r_nxt.trim = wr_data_in[`VCS_TRIM_MSB:0];
        default: ;
      endcase
    end
    unique case (r_r.state)
      vcs_pkg::VCS_IDLE: begin
        if (release_w) begin
          if (r_r.en) begin
            r_nxt.state = vcs_pkg::VCS_SETTLE;
            r_nxt.trim  = `VCS_TRIM_MID;
            r_nxt.idx   = `VCS_TOP_IDX;
            r_nxt.cnt   = settle_cnt;
            r_nxt.done  = 1'b0;
          end else begin
            r_nxt.state = vcs_pkg::VCS_DONE;
            r_nxt.done  = 1'b1;
          end
        end
      end
      vcs_pkg::VCS_SETTLE: begin
        if (r_r.cnt != 8'h00) begin
          r_nxt.cnt = r_r.cnt - 8'h01;
        end else begin
          // Fast oscillator: drop the trial bit; engine owns the word here
          r_nxt.trim = r_r.trim;
          if (osc_fast_in) begin
            r_nxt.trim[r_r.idx] = 1'b0;
          end
          if (r_r.idx == 3'h0) begin
            r_nxt.state = vcs_pkg::VCS_DONE;
            r_nxt.done  = 1'b1;
          end else begin
            r_nxt.idx                   = r_r.idx - 3'h1;
            r_nxt.trim[r_r.idx - 3'h1]  = 1'b1;
            r_nxt.cnt                   = settle_cnt;
          end
        end
      end
      vcs_pkg::VCS_DONE: ;
      default: r_nxt.state = vcs_pkg::VCS_IDLE;
    endcase
    // Hold wins over the state and done flag so a new run is armed for the next release
    if (r_nxt.hold) begin
      r_nxt.state = vcs_pkg::VCS_IDLE;
      r_nxt.done  = 1'b0;
    end
    r_nxt.rdata = r_r.rdata;
    if (rd_en_in) begin
      unique case (addr_in)
        `VCS_ADDR_TRIM:  r_nxt.rdata = {1'b0, r_r.trim};
        `VCS_ADDR_HOLD:  r_nxt.rdata = {7'h00, r_r.hold};
        `VCS_ADDR_CTRL:  r_nxt.rdata = {1'b0, r_r.settle, 3'h0, r_r.en};
        `VCS_ADDR_STATE: r_nxt.rdata = {7'h00, r_r.done};
        default:         r_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r_r        <= '0;
      r_r.hold   <= `VCS_HOLD_RST;
      r_r.en     <= `VCS_EN_RST;
      r_r.settle <= `VCS_STL_RST;
      r_r.trim   <= `VCS_TRIM_RST;
      r_r.state  <= vcs_pkg::VCS_IDLE;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign rd_data_out          = r_r.rdata;
  assign osc_tuning_word_out  = r_r.trim;
  assign synth_hold_reset_out = r_r.hold;
  assign osc_cal_finished_out = r_r.done;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  a_hold_idles: assert property (
    r_r.hold |=> (r_r.state == vcs_pkg::VCS_IDLE && !r_r.done) || !r_r.hold)
    else $error("hold set but engine not idle");
  a_skip_done: assert property (
    release_w && !r_r.en |=> r_r.done)
    else $error("skip did not set done");
  a_start_run: assert property (
    release_w && r_r.en |=> r_r.state == vcs_pkg::VCS_SETTLE
      && r_r.trim == `VCS_TRIM_MID && !r_r.done && r_r.cnt == $past(settle_cnt))
    else $error("calibration did not start");
  a_done_low_run: assert property (
    r_r.state == vcs_pkg::VCS_SETTLE |-> !osc_cal_finished_out)
    else $error("done high during run");
  a_settle_still: assert property (
    r_r.state == vcs_pkg::VCS_SETTLE && r_r.cnt != 8'h00 && !wr_en_in
      |=> $stable(osc_tuning_word_out) && r_r.cnt == $past(r_r.cnt) - 8'h01)
    else $error("trim moved during settle");
  a_last_step: assert property (
    r_r.state == vcs_pkg::VCS_SETTLE && r_r.cnt == 8'h00 && r_r.idx == 3'h0 && !r_nxt.hold
      |=> osc_cal_finished_out ##1 osc_cal_finished_out || r_r.hold)
    else $error("done not set after last step");
  a_fast_clears: assert property (
    r_r.state == vcs_pkg::VCS_SETTLE && r_r.cnt == 8'h00 && osc_fast_in && !wr_en_in
      |=> osc_tuning_word_out[$past(r_r.idx)] == 1'b0)
    else $error("fast oscillator bit kept");
  a_state_read: assert property (
    rd_en_in && addr_in == `VCS_ADDR_STATE |=> rd_data_out == {7'h00, $past(r_r.done)})
    else $error("status read wrong");
  a_trim_write: assert property (
    wr_en_in && addr_in == `VCS_ADDR_TRIM && r_r.state != vcs_pkg::VCS_SETTLE
      |=> osc_tuning_word_out == $past(wr_data_in[`VCS_TRIM_MSB:0]))
    else $error("trim write lost");
  a_skip_no_run: assert property (
    release_w && !r_r.en
      |=> r_r.state == vcs_pkg::VCS_DONE && $stable(osc_tuning_word_out))
    else $error("skip touched the tuning word");
  a_trial_bit: assert property (
    r_r.state == vcs_pkg::VCS_SETTLE |-> osc_tuning_word_out[r_r.idx] == 1'b1)
    else $error("trial bit not set during settle");
  a_low_bits_zero: assert property (
    r_r.state == vcs_pkg::VCS_SETTLE
      |-> (osc_tuning_word_out & ((7'h01 << r_r.idx) - 7'h01)) == 7'h00)
    else $error("bits below trial bit not clear");
  a_idx_steps: assert property (
    r_r.state == vcs_pkg::VCS_SETTLE && r_r.cnt == 8'h00 && r_r.idx != 3'h0 && !wr_en_in
      |=> r_r.state == vcs_pkg::VCS_SETTLE && r_r.idx == $past(r_r.idx) - 3'h1
      && r_r.cnt == $past(settle_cnt))
    else $error("search step not taken");
  a_done_kept: assert property (
    r_r.state == vcs_pkg::VCS_DONE && !r_nxt.hold |=> osc_cal_finished_out)
    else $error("done dropped without hold");
  a_abort_idle: assert property (
    r_r.state == vcs_pkg::VCS_SETTLE && r_nxt.hold
      |=> r_r.state == vcs_pkg::VCS_IDLE && !osc_cal_finished_out)
    else $error("run not aborted by hold");

  // Register map; a read returns what was held before its strobe
  a_hold_write: assert property (
    wr_en_in && addr_in == `VCS_ADDR_HOLD
      |=> synth_hold_reset_out == $past(wr_data_in[`VCS_HOLD_BIT]))
    else $error("hold write lost");
  a_ctrl_write: assert property (
    wr_en_in && addr_in == `VCS_ADDR_CTRL
      |=> r_r.settle == $past(wr_data_in[`VCS_STL_MSB:`VCS_STL_LSB])
      && r_r.en == $past(wr_data_in[`VCS_EN_BIT]))
    else $error("control write lost");
  a_ctrl_read: assert property (
    rd_en_in && addr_in == `VCS_ADDR_CTRL
      |=> rd_data_out == {1'b0, $past(r_r.settle), 3'h0, $past(r_r.en)})
    else $error("control read wrong");
  a_trim_read: assert property (
    rd_en_in && addr_in == `VCS_ADDR_TRIM
      |=> rd_data_out == {1'b0, $past(osc_tuning_word_out)})
    else $error("tuning word read wrong");
  a_hold_read: assert property (
    rd_en_in && addr_in == `VCS_ADDR_HOLD
      |=> rd_data_out == {7'h00, $past(synth_hold_reset_out)})
    else $error("hold read wrong");
  a_rdata_kept: assert property (
    !rd_en_in |=> $stable(rd_data_out))
    else $error("read data moved without read");
  a_unmapped_read: assert property (
    rd_en_in && !(addr_in inside {`VCS_ADDR_TRIM, `VCS_ADDR_HOLD,
                                  `VCS_ADDR_CTRL, `VCS_ADDR_STATE})
      |=> rd_data_out == 8'h00)
    else $error("unmapped read not zero");

  c_full_run:  cover property (r_r.state == vcs_pkg::VCS_SETTLE ##1 r_r.done);
  c_abort:     cover property (r_r.state == vcs_pkg::VCS_SETTLE ##1 r_r.hold);
  c_skip:      cover property (release_w && !r_r.en);
  c_rehold:    cover property (r_r.done ##1 r_r.hold);
  c_trim_read: cover property (r_r.done && rd_en_in && addr_in == `VCS_ADDR_TRIM);

endmodule : vcs_sequencer

// ---- testbench/vcs_sequencer_bench.sv ----
`timescale 1ns/1ps
`include "vcs_consts.svh"
module vcs_sequencer_bench;
  logic       clk_sys_in, nrst_in, wr_en_in, rd_en_in, osc_fast_in;
  logic [7:0] addr_in, wr_data_in, rd_data_out;
  logic [6:0] osc_tuning_word_out, tgt;
  logic       synth_hold_reset_out, osc_cal_finished_out;
  int         fails, comparisons, n, t_short, t_long;

  vcs_sequencer #(.SETTLE_UNIT_CYC(1)) dut_u (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .addr_in(addr_in), .wr_en_in(wr_en_in),
    .wr_data_in(wr_data_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
    .osc_fast_in(osc_fast_in), .osc_tuning_word_out(osc_tuning_word_out),
    .synth_hold_reset_out(synth_hold_reset_out), .osc_cal_finished_out(osc_cal_finished_out));

  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  // Comparator model; one cycle of lag is covered by the settle wait
  always @(posedge clk_sys_in) osc_fast_in <= (osc_tuning_word_out > tgt);

  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    wr_en_in   <= 1'b1;
    addr_in    <= a;
    wr_data_in <= d;
    @(posedge clk_sys_in);
    wr_en_in <= 1'b0;
    #1;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    rd_en_in <= 1'b1;
    addr_in  <= a;
    @(posedge clk_sys_in);
    rd_en_in <= 1'b0;
    #1;
    chk("rd_data", exp, rd_data_out);
  endtask : rd

  // Arm, program and release; returns cycles waited after the release edge
  task cal(input logic [2:0] stl, input logic [6:0] t, input logic en, output int cyc);
    tgt = t;
    wr(`VCS_ADDR_HOLD, 8'h01);
    chk("done_held", 8'h00, {7'h00, osc_cal_finished_out});
    chk("hold_set", 8'h01, {7'h00, synth_hold_reset_out});
    wr(`VCS_ADDR_CTRL, {1'b0, stl, 3'h0, en});
    wr(`VCS_ADDR_HOLD, 8'h00);
    cyc = 0;
    if (en) chk("done_run", 8'h00, {7'h00, osc_cal_finished_out});
    // Poll up to 400 cycles for done while the search steps the tuning word
    while (osc_cal_finished_out !== 1'b1 && cyc < 400) begin
      @(posedge clk_sys_in);
      #1;
      cyc++;
    end
    chk("done_seen", 8'h01, {7'h00, osc_cal_finished_out});
  endtask : cal

  task print_verdict;
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  initial begin
    #(3000 * 40);
    fails++;
    print_verdict;
  end

  initial begin
    nrst_in = 1'b0;
    wr_en_in = 1'b0;
    rd_en_in = 1'b0;
    addr_in = 8'h00;
    wr_data_in = 8'h00;
    tgt = 7'h00;
    repeat (4) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    rd(`VCS_ADDR_HOLD, 8'h00);
    rd(`VCS_ADDR_CTRL, 8'h40);
    rd(`VCS_ADDR_STATE, 8'h00);
    rd(`VCS_ADDR_TRIM, 8'h00);
    rd(8'h60, 8'h00);
    cal(3'h0, 7'h00, 1'b0, n);
    chk("skip_cycles", 8'h00, n[7:0]);
    rd(`VCS_ADDR_STATE, 8'h01);
    cal(3'h1, 7'h2b, 1'b1, t_short);
    chk("trim_out", 8'h2b, {1'b0, osc_tuning_word_out});
    chk("run_cycles", 8'h15, t_short[7:0]);
    rd(`VCS_ADDR_TRIM, 8'h2b);
    rd(`VCS_ADDR_STATE, 8'h01);
    cal(3'h7, 7'h7f, 1'b1, t_long);
    chk("trim_out", 8'h7f, {1'b0, osc_tuning_word_out});
    chk("run_cycles", 8'h3f, t_long[7:0]);
    chk("longer", 8'h01, {7'h00, t_long > t_short});
    rd(`VCS_ADDR_CTRL, 8'h71);
    wr(`VCS_ADDR_HOLD, 8'h01);
    wr(`VCS_ADDR_HOLD, 8'h00);
    chk("done_run", 8'h00, {7'h00, osc_cal_finished_out});
    repeat (5) @(posedge clk_sys_in);
    wr(`VCS_ADDR_HOLD, 8'h01);
    chk("done_abort", 8'h00, {7'h00, osc_cal_finished_out});
    repeat (80) @(posedge clk_sys_in);
    #1;
    chk("done_idle", 8'h00, {7'h00, osc_cal_finished_out});
    cal(3'h4, 7'h00, 1'b0, n);
    wr(`VCS_ADDR_TRIM, 8'h15);
    rd(`VCS_ADDR_TRIM, 8'h15);
    chk("trim_out", 8'h15, {1'b0, osc_tuning_word_out});
    chk("hold_out", 8'h00, {7'h00, synth_hold_reset_out});
    print_verdict;
  end
endmodule : vcs_sequencer_bench
